// file: hdl/rbs_core.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rbs_core
    import rbs_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [AXI_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    rbs_state_t             st_reg;
    rbs_state_t             st_next;

    logic [MEM_IDX_W-1:0]   cmd_idx;
    logic [3:0]             cmd_op;
    logic [7:0]             alu_result;
    logic                   alu_to_acc;
    logic                   alu_to_mem;
    rbs_flags_t             alu_flags;
    logic                   alu_ok;
    logic                   wr_fire;
    logic                   wr_is_mem;
    logic [MEM_IDX_W-1:0]   wr_mem_idx;
    logic                   rd_is_mem;
    logic [MEM_IDX_W-1:0]   rd_mem_idx;

    // Protection bits carry no meaning for this block.
    logic                   unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

    assign cmd_op     = st_reg.wdata[CMD_OP_LSB +: 4];
    assign cmd_idx    = st_reg.wdata[CMD_IDX_LSB +: MEM_IDX_W];
    assign wr_fire    = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    assign wr_is_mem  = (st_reg.aw_addr[7:6] == MEM_PAGE);
    assign wr_mem_idx = st_reg.aw_addr[2 +: MEM_IDX_W];
    assign rd_is_mem  = (s_axi_araddr[7:6] == MEM_PAGE);
    assign rd_mem_idx = s_axi_araddr[2 +: MEM_IDX_W];

    rbs_alu u_alu (
        .op        (cmd_op),
        .mem_in    (st_reg.mem[cmd_idx]),
        .acc_in    (st_reg.acc),
        .flags_in  (st_reg.flags),
        .result    (alu_result),
        .to_acc    (alu_to_acc),
        .to_mem    (alu_to_mem),
        .flags_out (alu_flags),
        .op_ok     (alu_ok)
    );

    always_comb begin
        st_next = st_reg;

        // Write address and data are captured independently, in either order.
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_held = 1'b1;
            st_next.wdata  = s_axi_wdata;
            st_next.wstrb  = s_axi_wstrb;
        end

        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (wr_fire) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = RESP_OKAY;
            if (wr_is_mem) begin
                if (st_reg.wstrb[0]) begin
                    st_next.mem[wr_mem_idx] = st_reg.wdata[7:0];
                end
            end else if (st_reg.aw_addr[7:2] == REG_CMD[7:2]) begin
                // A command runs only if both low byte lanes are written.
                if (st_reg.wstrb[1:0] == 2'h3 && alu_ok) begin
                    st_next.last_cmd = st_reg.wdata[15:0];
                    st_next.flags    = alu_flags;
                    if (alu_to_acc) begin
                        st_next.acc = alu_result;
                    end
                    if (alu_to_mem) begin
                        st_next.mem[cmd_idx] = alu_result;
                    end
                end else begin
                    st_next.bresp = RESP_SLVERR;
                end
            end else if (st_reg.aw_addr[7:2] == REG_ACC[7:2]) begin
                if (st_reg.wstrb[0]) begin
                    st_next.acc = st_reg.wdata[7:0];
                end
            end else if (st_reg.aw_addr[7:2] == REG_FLAGS[7:2]) begin
                if (st_reg.wstrb[0]) begin
                    st_next.flags = rbs_flags_t'(st_reg.wdata[5:0]);
                end
            end else begin
                st_next.bresp = RESP_SLVERR;
            end
        end

        st_next.awready = !st_next.aw_held && !st_next.bvalid;
        st_next.wready  = !st_next.w_held && !st_next.bvalid;

        // Reads answer in the cycle after the address is taken.
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            st_next.rdata  = '0;
            if (rd_is_mem) begin
                st_next.rdata[7:0] = st_reg.mem[rd_mem_idx];
            end else if (s_axi_araddr[7:2] == REG_CMD[7:2]) begin
                st_next.rdata[15:0] = st_reg.last_cmd;
            end else if (s_axi_araddr[7:2] == REG_ACC[7:2]) begin
                st_next.rdata[7:0] = st_reg.acc;
            end else if (s_axi_araddr[7:2] == REG_FLAGS[7:2]) begin
                st_next.rdata[5:0] = st_reg.flags;
            end else begin
                st_next.rresp = RESP_SLVERR;
            end
        end
        st_next.arready = !st_next.rvalid;

        if (!rst_n) begin
            st_next          = '0;
            st_next.acc      = ACC_RESET;
            st_next.flags    = rbs_flags_t'(FLAGS_RESET);
            st_next.awready  = 1'b1;
            st_next.wready   = 1'b1;
            st_next.arready  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

endmodule : rbs_core
`default_nettype wire

// file: hdl/rbs_pkg.sv
// Contract
// - Rotate left into accumulator, memory and flags kept
// - Rotate left through carry, result to memory
// - Rotate left through carry into accumulator
// - Rotate memory right, no flag touched
// - Rotate right into accumulator, memory kept
// - Rotate right through carry, result to memory
// - Rotate right through carry into accumulator
// - Accumulator minus memory minus inverted carry, to accumulator
// - Same difference written into memory byte
// - Carry cleared when negative, set otherwise
// - Subtract sets six flags; carry rotates only carry
package rbs_pkg;

    localparam int          AXI_ADDR_W  = 8;
    localparam int          AXI_DATA_W  = 32;
    localparam int          MEM_DEPTH   = 16;
    localparam int          MEM_IDX_W   = 4;

    localparam logic [7:0]  REG_CMD     = 8'h00;
    localparam logic [7:0]  REG_ACC     = 8'h04;
    localparam logic [7:0]  REG_FLAGS   = 8'h08;
    localparam logic [1:0]  MEM_PAGE    = 2'h1;

    localparam int          CMD_OP_LSB  = 0;
    localparam int          CMD_IDX_LSB = 8;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    localparam logic [3:0]  OP_ROTL_MEM               = 4'h0;
    localparam logic [3:0]  OP_ROTL_TO_ACC            = 4'h1;
    localparam logic [3:0]  OP_ROTL_THRU_CARRY        = 4'h2;
    localparam logic [3:0]  OP_ROTL_THRU_CARRY_TO_ACC = 4'h3;
    localparam logic [3:0]  OP_ROTR_MEM               = 4'h4;
    localparam logic [3:0]  OP_ROTR_TO_ACC            = 4'h5;
    localparam logic [3:0]  OP_ROTR_THRU_CARRY        = 4'h6;
    localparam logic [3:0]  OP_ROTR_THRU_CARRY_TO_ACC = 4'h7;
    localparam logic [3:0]  OP_SUB_BORROW_TO_ACC      = 4'h8;
    localparam logic [3:0]  OP_SUB_BORROW_TO_MEM      = 4'h9;

    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [5:0]  FLAGS_RESET = 6'h00;

    // Flag bit order in the flags register: carry is bit 0, compare-zero bit 5.
    typedef struct packed {
        logic compare_zero_flag;
        logic signed_compare_flag;
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } rbs_flags_t;

    typedef struct packed {
        logic                          awready;
        logic                          aw_held;
        logic [AXI_ADDR_W-1:0]         aw_addr;
        logic                          wready;
        logic                          w_held;
        logic [AXI_DATA_W-1:0]         wdata;
        logic [3:0]                    wstrb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [AXI_DATA_W-1:0]         rdata;
        logic [1:0]                    rresp;
        logic [7:0]                    acc;
        rbs_flags_t                    flags;
        logic [15:0]                   last_cmd;
        logic [MEM_DEPTH-1:0][7:0]     mem;
    } rbs_state_t;

endpackage : rbs_pkg

// file: hdl/rbs_alu.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_alu
    import rbs_pkg::*;
(
    input  wire logic [3:0]  op,
    input  wire logic [7:0]  mem_in,
    input  wire logic [7:0]  acc_in,
    input  wire rbs_flags_t  flags_in,
    output logic      [7:0]  result,
    output logic             to_acc,
    output logic             to_mem,
    output rbs_flags_t       flags_out,
    output logic             op_ok
);

    logic [8:0] diff;
    logic [4:0] nib;

    // A borrow of one is taken when the carry is clear.
    assign diff = {1'b0, acc_in} - {1'b0, mem_in} - {8'h00, ~flags_in.carry_flag};
    assign nib  = {1'b0, acc_in[3:0]} - {1'b0, mem_in[3:0]} - {4'h0, ~flags_in.carry_flag};

    always_comb begin
        result    = mem_in;
        to_acc    = 1'b0;
        to_mem    = 1'b0;
        flags_out = flags_in;
        op_ok     = 1'b1;
        case (op)
            OP_ROTL_MEM: begin
                result = {mem_in[6:0], mem_in[7]};
                to_mem = 1'b1;
            end
            OP_ROTL_TO_ACC: begin
                result = {mem_in[6:0], mem_in[7]};
                to_acc = 1'b1;
            end
            OP_ROTL_THRU_CARRY: begin
                result               = {mem_in[6:0], flags_in.carry_flag};
                flags_out.carry_flag = mem_in[7];
                to_mem               = 1'b1;
            end
            OP_ROTL_THRU_CARRY_TO_ACC: begin
                result               = {mem_in[6:0], flags_in.carry_flag};
                flags_out.carry_flag = mem_in[7];
                to_acc               = 1'b1;
            end
            OP_ROTR_MEM: begin
                result = {mem_in[0], mem_in[7:1]};
                to_mem = 1'b1;
            end
            OP_ROTR_TO_ACC: begin
                result = {mem_in[0], mem_in[7:1]};
                to_acc = 1'b1;
            end
            OP_ROTR_THRU_CARRY: begin
                result               = {flags_in.carry_flag, mem_in[7:1]};
                flags_out.carry_flag = mem_in[0];
                to_mem               = 1'b1;
            end
            OP_ROTR_THRU_CARRY_TO_ACC: begin
                result               = {flags_in.carry_flag, mem_in[7:1]};
                flags_out.carry_flag = mem_in[0];
                to_acc               = 1'b1;
            end
            OP_SUB_BORROW_TO_ACC, OP_SUB_BORROW_TO_MEM: begin
                result = diff[7:0];
                to_acc = (op == OP_SUB_BORROW_TO_ACC);
                to_mem = (op == OP_SUB_BORROW_TO_MEM);
                flags_out.carry_flag          = ~diff[8];
                flags_out.aux_carry_flag      = ~nib[4];
                flags_out.zero_flag           = (diff[7:0] == 8'h00);
                flags_out.overflow_flag       = (acc_in[7] != mem_in[7]) &&
                                                (diff[7] != acc_in[7]);
                flags_out.signed_compare_flag = ((acc_in[7] != mem_in[7]) &&
                                                (diff[7] != acc_in[7])) ^ diff[7];
                // Compare-zero chains with the previous zero flag for multi-byte work.
                flags_out.compare_zero_flag   = (diff[7:0] == 8'h00) &&
                                                flags_in.zero_flag;
            end
            default: begin
                op_ok = 1'b0;
            end
        endcase
    end

endmodule : rbs_alu
`default_nettype wire

// file: bench/rbs_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_core_assertions
    import rbs_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    r_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("write answer off");
    ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during read answer");
    w_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during write answer");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read not released");
endmodule : rbs_core_assertions

bind rbs_core rbs_core_assertions u_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: bench/tb_rotate_and_borrow_subtract_ops.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_and_borrow_subtract_ops
    import rbs_pkg::*;
;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ok;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr, m_acc, m_mem, a, v, ma;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, op, idx;
    logic [1:0]  bresp, rresp;
    logic [5:0]  m_fl;
    logic [15:0] m_cmd;
    int          failures = 0, comparisons = 0, cyc = 0;

    rbs_core dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            aw_ok |= awready;
            w_ok |= wready;
        end while (!(aw_ok && w_ok));
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    task automatic run(input logic [3:0] o);
        logic [7:0] r;
        logic       c, ovf;
        int         d, h;
        c = m_fl[0];
        d = int'(m_acc) - int'(m_mem) - int'(!c);
        h = int'(m_acc[3:0]) - int'(m_mem[3:0]) - int'(!c);
        r = d[7:0];
        ovf = (m_acc[7] != m_mem[7]) && (r[7] != m_acc[7]);
        case (o)
            4'h0: m_mem = {m_mem[6:0], m_mem[7]};
            4'h1: m_acc = {m_mem[6:0], m_mem[7]};
            4'h2: {m_fl[0], m_mem} = {m_mem, c};
            4'h3: {m_fl[0], m_acc} = {m_mem, c};
            4'h4: m_mem = {m_mem[0], m_mem[7:1]};
            4'h5: m_acc = {m_mem[0], m_mem[7:1]};
            4'h6: {m_mem, m_fl[0]} = {c, m_mem};
            4'h7: {m_acc, m_fl[0]} = {c, m_mem};
            default: begin
                if (o == 4'h8) m_acc = r;
                else m_mem = r;
                m_fl = {r == 8'h0 && m_fl[2], ovf ^ r[7], ovf, r == 8'h0, h >= 0, d >= 0};
            end
        endcase
    endtask : run

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        rst_n = 1'b0;
        void'($urandom(94));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_ACC, 32'h0, RESP_OKAY);
        rd(REG_FLAGS, 32'h0, RESP_OKAY);
        rd(REG_CMD, 32'h0, RESP_OKAY);
        m_cmd = 16'h0;
        for (int t = 0; t < 44; t++) begin
            op = 4'(t % 11);
            idx = 4'($urandom % 16);
            ma = {MEM_PAGE, idx, 2'h0};
            a = 8'($urandom);
            v = (t > 32) ? a : 8'($urandom);
            m_fl = 6'($urandom);
            wr(REG_ACC, {24'h0, a}, RESP_OKAY);
            wr(REG_FLAGS, {26'h0, m_fl}, RESP_OKAY);
            wr(ma, {24'h0, v}, RESP_OKAY);
            m_acc = a;
            m_mem = v;
            wstrb <= (t == 13) ? 4'h2 : 4'hf;
            ok = (op < 4'ha) && (t != 13);
            wr(REG_CMD, {20'h0, idx, 4'h0, op}, ok ? RESP_OKAY : RESP_SLVERR);
            wstrb <= 4'hf;
            if (ok) begin
                run(op);
                m_cmd = {4'h0, idx, 4'h0, op};
            end
            rd(REG_ACC, {24'h0, m_acc}, RESP_OKAY);
            rd(REG_FLAGS, {26'h0, m_fl}, RESP_OKAY);
            rd(ma, {24'h0, m_mem}, RESP_OKAY);
            rd(REG_CMD, {16'h0, m_cmd}, RESP_OKAY);
            $display("test %0d op %0d done", t, op);
        end
        // A reset in mid-run must clear accumulator, flags, memory and the command echo.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_ACC, 32'h0, RESP_OKAY);
        rd(REG_FLAGS, 32'h0, RESP_OKAY);
        rd(ma, 32'h0, RESP_OKAY);
        rd(REG_CMD, 32'h0, RESP_OKAY);
        $display("test reset done");
        rd(8'h0c, 32'h0, RESP_SLVERR);
        wr(8'h80, 32'h5a, RESP_SLVERR);
        wrap_up();
    end
endmodule : tb_rotate_and_borrow_subtract_ops
`default_nettype wire
